// ==== logic/mode_cfg_pkg.sv ====
/*
  Constants, field layout and types of the general mode configuration
  block. Assumes a byte-wide register port and a single 100 MHz clock.
*/
// Summary of operation
// - Bit-order bit set: CRC runs MSB first, both result bytes bit-reversed.
// - Bit-order bit is ignored while RF communication is in progress.
// - With sync detection on, receiver stays off until byte F0h arrives.
// - With sync detection on, every transmitted frame gets sync byte F0h.
// - Transmit-wait set, reader or initiator: transmitter needs own field.
// - Receive-wait set, target or card: counter starts after external field.
// - Polarity bit: 1 treats secure input active high, 0 active low.
// - Internal envelope signal is coded active low.
// - A register write that changes the polarity bit raises the polarity-change event.
// - Mode-detector-disable bit set switches the mode detector off.
// - Mode detector runs only during the automatic anticollision command.
// - Preset field picks CRC start 0000, 6363, A671 or FFFF for calculation.
// - During communication the CRC preset follows the active mode settings.
// - Register resets to 3Bh; all eight bits read and write.
package mode_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] GEN_MODE_OFFSET = 8'h11;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 8'h20;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFFSET = 8'h21;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFFSET = 8'h22;

  localparam logic [DATA_W-1:0] GEN_MODE_RESET = 8'h3b;
  localparam logic [DATA_W-1:0] SYNC_BYTE = 8'hf0;

  localparam int MSB_ORDER_BIT = 7;
  localparam int SYNC_DETECT_BIT = 6;
  localparam int TX_WAIT_BIT = 5;
  localparam int RX_WAIT_BIT = 4;
  localparam int POLARITY_BIT = 3;
  localparam int MODE_DET_OFF_BIT = 2;
  localparam int PRESET_MSB = 1;
  localparam int PRESET_LSB = 0;

  localparam int EV_COUNT = 2;
  localparam int EV_POLARITY = 0;
  localparam int EV_SYNC_FOUND = 1;
  localparam logic [EV_COUNT-1:0] EV_RESET = 2'h0;

  localparam logic [15:0] PRESET_ZERO = 16'h0000;
  localparam logic [15:0] PRESET_6363 = 16'h6363;
  localparam logic [15:0] PRESET_A671 = 16'ha671;
  localparam logic [15:0] PRESET_FFFF = 16'hffff;

  typedef enum logic [1:0] {
    SYNC_OFF = 2'b00,
    SYNC_HUNT = 2'b01,
    SYNC_LOCKED = 2'b10
  } sync_state_type;

  function automatic logic [15:0] presetFor(input logic [1:0] sel);
    unique case (sel)
      2'b00: presetFor = PRESET_ZERO;
      2'b01: presetFor = PRESET_6363;
      2'b10: presetFor = PRESET_A671;
      2'b11: presetFor = PRESET_FFFF;
    endcase
  endfunction

  function automatic logic [7:0] reverseByte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      reverseByte[i] = b[7-i];
    end
  endfunction

endpackage

// ==== logic/crc_preset_select.sv ====
/*
  CRC start value selection. Assumes the mode-derived preset is supplied
  by the transmit/receive framing logic outside this block.
*/
`timescale 1ns/1ps
module crc_preset_select
  import mode_cfg_pkg::*;
(
  input wire logic [1:0] presetSel,
  input wire logic rfCommActive,
  input wire logic [15:0] modePreset,
  output logic [15:0] presetValue
);
  always_comb
  begin
    // Communication overrides the software field
    if (rfCommActive)
    begin
      presetValue = modePreset;
    end
    else
    begin
      presetValue = presetFor(presetSel);
    end
  end
endmodule // crc_preset_select

// ==== logic/crc_result_mirror.sv ====
/*
  Optional bit reversal of each CRC result byte. Assumes a 16-bit raw
  result from the CRC co-processor.
*/
`timescale 1ns/1ps
module crc_result_mirror #(
  parameter int BYTES = 2
) (
  input wire logic [8*BYTES-1:0] rawResult,
  input wire logic mirrorEn,
  output logic [8*BYTES-1:0] outResult
);
  genvar g;
  generate
    for (g = 0; g < BYTES; g++)
    begin : gByte
      assign outResult[8*g+7:8*g] = mirrorEn ?
        mode_cfg_pkg::reverseByte(rawResult[8*g+7:8*g]) :
        rawResult[8*g+7:8*g];
    end
  endgenerate
endmodule // crc_result_mirror

// ==== logic/general_mode_ctrl.sv ====
/*
  General mode configuration register with the logic it steers: CRC
  order and preset, sync-byte gating, field-gated transmit and receive
  wait start, secure input polarity, mode detector enable and events.
  Assumes a synchronous register port and that the framing engine
  signals communication, frames and received bytes in clk_sys domain.
*/
`timescale 1ns/1ps
module general_mode_ctrl
  import mode_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [mode_cfg_pkg::ADDR_W-1:0] regAddr,
  input wire logic [mode_cfg_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [mode_cfg_pkg::DATA_W-1:0] regRdData,
  input wire logic rfCommActive,
  input wire logic [15:0] modePreset,
  input wire logic [15:0] crcRawResult,
  output logic crcMsbFirst,
  output logic [15:0] crcPresetValue,
  output logic [15:0] crcResultOut,
  input wire logic rxFrameStart,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  output logic rxActive,
  input wire logic txRequest,
  input wire logic readerMode,
  input wire logic ownFieldOn,
  output logic txStart,
  output logic txSyncPrefix,
  input wire logic rxWaitRequest,
  input wire logic targetMode,
  input wire logic extFieldDetected,
  output logic rxWaitCountStart,
  input wire logic secureSignalIn,
  output logic secureInputActive,
  output logic envelopeN,
  input wire logic autoAnticollActive,
  output logic modeDetectorRun,
  output logic irq
);
  import mode_cfg_pkg::*;

  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] off
  );
    hit = (a == off);
  endfunction

  logic [DATA_W-1:0] modeReg_q;
  logic [DATA_W-1:0] rdData_q;
  logic [EV_COUNT-1:0] status_q;
  logic [EV_COUNT-1:0] status_d;
  logic [EV_COUNT-1:0] enable_q;
  logic [EV_COUNT-1:0] clearMask;
  logic [EV_COUNT-1:0] events;
  sync_state_type syncState_q;
  sync_state_type syncState_d;
  logic syncFound;
  logic polarityFlip;
  logic modeWrite;
  logic txSyncPrefix_q;
  logic rxWaitPending_q;
  logic rxWaitAllowed;
  logic crcMsbFirst_q;
  logic [15:0] crc_start_value_sel_q;
  logic [15:0] crcResult_q;
  logic [15:0] presetNext;
  logic [15:0] mirrored;
  logic secureActive_q;
  logic envelopeN_q;
  logic modeDetRun_q;
  logic effMsbFirst;

  // Register port

  assign modeWrite = regWrEn && hit(regAddr, GEN_MODE_OFFSET);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      modeReg_q <= GEN_MODE_RESET;
    end
    else if (modeWrite)
    begin
      modeReg_q <= regWrData;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      enable_q <= EV_RESET;
    end
    else if (regWrEn && hit(regAddr, IRQ_ENABLE_OFFSET))
    begin
      enable_q <= regWrData[EV_COUNT-1:0];
    end
  end

  // Unmapped and write-only addresses read as zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdData_q <= '0;
    end
    else if (regRdEn)
    begin
      if (hit(regAddr, GEN_MODE_OFFSET))
      begin
        rdData_q <= modeReg_q;
      end
      else if (hit(regAddr, IRQ_STATUS_OFFSET))
      begin
        rdData_q <= {{(DATA_W-EV_COUNT){1'b0}}, status_q};
      end
      else if (hit(regAddr, IRQ_ENABLE_OFFSET))
      begin
        rdData_q <= {{(DATA_W-EV_COUNT){1'b0}}, enable_q};
      end
      else
      begin
        rdData_q <= '0;
      end
    end
    else
    begin
      rdData_q <= '0;
    end
  end

  assign regRdData = rdData_q;

  // Events and interrupt

  // Compared against the stored bit, so rewriting the same value is quiet
  assign polarityFlip = modeWrite &&
    (regWrData[POLARITY_BIT] != modeReg_q[POLARITY_BIT]);

  assign clearMask = (regWrEn && hit(regAddr, IRQ_CLEAR_OFFSET)) ?
    regWrData[EV_COUNT-1:0] : '0;

  always_comb
  begin
    events = '0;
    events[EV_POLARITY] = polarityFlip;
    events[EV_SYNC_FOUND] = syncFound;
    // Set wins over a clear in the same cycle
    status_d = (status_q & ~clearMask) | events;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      status_q <= EV_RESET;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  assign irq = |(status_q & enable_q);

  // CRC order, preset and result

  assign effMsbFirst = modeReg_q[MSB_ORDER_BIT] && !rfCommActive;

  crc_preset_select uPreset (
    .presetSel(modeReg_q[PRESET_MSB:PRESET_LSB]),
    .rfCommActive(rfCommActive),
    .modePreset(modePreset),
    .presetValue(presetNext)
  );

  crc_result_mirror #(
    .BYTES(2)
  ) uMirror (
    .rawResult(crcRawResult),
    .mirrorEn(effMsbFirst),
    .outResult(mirrored)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      crcMsbFirst_q <= 1'b0;
      crc_start_value_sel_q <= PRESET_ZERO;
      crcResult_q <= '0;
    end
    else
    begin
      crcMsbFirst_q <= effMsbFirst;
      crc_start_value_sel_q <= presetNext;
      crcResult_q <= mirrored;
    end
  end

  assign crcMsbFirst = crcMsbFirst_q;
  assign crcPresetValue = crc_start_value_sel_q;
  assign crcResultOut = crcResult_q;

  // Sync byte gating of the receiver

  assign syncFound = (syncState_q == SYNC_HUNT) && rxByteValid &&
    (rxByte == SYNC_BYTE);

  always_comb
  begin
    syncState_d = syncState_q;
    unique case (syncState_q)
      SYNC_OFF:
      begin
        if (rxFrameStart)
        begin
          syncState_d = modeReg_q[SYNC_DETECT_BIT] ? SYNC_HUNT :
            SYNC_LOCKED;
        end
      end
      SYNC_HUNT:
      begin
        if (syncFound)
        begin
          syncState_d = SYNC_LOCKED;
        end
      end
      SYNC_LOCKED:
      begin
        // A new frame re-arms the hunt when sync detection is on
        if (rxFrameStart && modeReg_q[SYNC_DETECT_BIT])
        begin
          syncState_d = SYNC_HUNT;
        end
      end
      default:
      begin
        syncState_d = SYNC_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      syncState_q <= SYNC_OFF;
    end
    else
    begin
      syncState_q <= syncState_d;
    end
  end

  assign rxActive = (syncState_q == SYNC_LOCKED);

  // Transmit start and sync prefix

  // Refused requests are dropped; the framer must retry
  assign txStart = txRequest && (ownFieldOn || !readerMode ||
    !modeReg_q[TX_WAIT_BIT]);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      txSyncPrefix_q <= 1'b0;
    end
    else if (txStart)
    begin
      txSyncPrefix_q <= modeReg_q[SYNC_DETECT_BIT];
    end
  end

  assign txSyncPrefix = txSyncPrefix_q;

  // Receive wait counter start, held until the field appears

  assign rxWaitAllowed = extFieldDetected || !targetMode ||
    !modeReg_q[RX_WAIT_BIT];
  assign rxWaitCountStart = (rxWaitRequest || rxWaitPending_q) &&
    rxWaitAllowed;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rxWaitPending_q <= 1'b0;
    end
    else if (rxWaitCountStart)
    begin
      rxWaitPending_q <= 1'b0;
    end
    else if (rxWaitRequest)
    begin
      rxWaitPending_q <= 1'b1;
    end
  end

  // Secure input polarity and envelope

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      secureActive_q <= 1'b0;
      envelopeN_q <= 1'b1;
    end
    else
    begin
      secureActive_q <= modeReg_q[POLARITY_BIT] ? secureSignalIn :
        !secureSignalIn;
      envelopeN_q <= modeReg_q[POLARITY_BIT] ? !secureSignalIn :
        secureSignalIn;
    end
  end

  assign secureInputActive = secureActive_q;
  assign envelopeN = envelopeN_q;

  // Mode detector

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      modeDetRun_q <= 1'b0;
    end
    else
    begin
      modeDetRun_q <= autoAnticollActive &&
        !modeReg_q[MODE_DET_OFF_BIT];
    end
  end

  assign modeDetectorRun = modeDetRun_q;

  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence modeWriteS;
    regWrEn && hit(regAddr, GEN_MODE_OFFSET);
  endsequence

  sequence polarityFlipS;
    modeWriteS ##0
      (regWrData[POLARITY_BIT] != modeReg_q[POLARITY_BIT]);
  endsequence

  sequence huntSyncS;
    syncState_q == SYNC_HUNT ##0 rxByteValid && rxByte == SYNC_BYTE;
  endsequence

  reset_value_a: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    rst |=> modeReg_q == GEN_MODE_RESET)
    else $error("mode register not at reset value");

  write_read_a: assert property (
    modeWriteS ##1 (regRdEn && hit(regAddr, GEN_MODE_OFFSET) && !regWrEn)
    |=> regRdData == $past(regWrData, 2))
    else $error("mode register read-back mismatch");

  crc_mirror_a: assert property (
    !rst && modeReg_q[MSB_ORDER_BIT] && !rfCommActive
    |=> crcResultOut[15:8] == reverseByte($past(crcRawResult[15:8])) &&
        crcResultOut[7:0] == reverseByte($past(crcRawResult[7:0])))
    else $error("crc result not bit-reversed");

  comm_ignore_a: assert property (
    !rst && rfCommActive |=> !crcMsbFirst &&
      crcResultOut == $past(crcRawResult))
    else $error("bit order not ignored during communication");

  rx_gate_a: assert property (
    huntSyncS |=> rxActive ##0 status_q[EV_SYNC_FOUND])
    else $error("receiver not activated after sync byte");

  rx_hold_a: assert property (
    syncState_q == SYNC_HUNT |-> !rxActive)
    else $error("receiver active before sync byte");

  tx_prefix_a: assert property (
    txStart |=> txSyncPrefix == $past(modeReg_q[SYNC_DETECT_BIT]))
    else $error("sync prefix flag wrong");

  tx_wait_a: assert property (
    txRequest && readerMode && modeReg_q[TX_WAIT_BIT]
    |-> txStart == ownFieldOn)
    else $error("transmitter start not gated by own field");

  rx_wait_a: assert property (
    rxWaitRequest && targetMode && modeReg_q[RX_WAIT_BIT] &&
    !extFieldDetected ##1 extFieldDetected && targetMode &&
    modeReg_q[RX_WAIT_BIT] |-> rxWaitCountStart)
    else $error("held receive wait start lost");

  polarity_a: assert property (
    !rst |=> secureInputActive == !envelopeN &&
    secureInputActive == ($past(modeReg_q[POLARITY_BIT]) ?
      $past(secureSignalIn) : !$past(secureSignalIn)))
    else $error("secure input polarity wrong");

  pol_event_a: assert property (
    polarityFlipS |=> status_q[EV_POLARITY])
    else $error("polarity change event missing");

  mode_det_a: assert property (
    modeDetectorRun |-> $past(autoAnticollActive) &&
      !$past(modeReg_q[MODE_DET_OFF_BIT]))
    else $error("mode detector running when not allowed");

  preset_a: assert property (
    !rst && !rfCommActive |=> crcPresetValue ==
      presetFor($past(modeReg_q[PRESET_MSB:PRESET_LSB])))
    else $error("crc preset does not follow field");

  auto_preset_a: assert property (
    !rst && rfCommActive |=> crcPresetValue == $past(modePreset))
    else $error("crc preset not taken from mode settings");

endmodule // general_mode_ctrl

// ==== verif/test_transceiver_general_mode_config.sv ====
/*
  Self-checking bench for the general mode configuration block.
  Assumes mode_cfg_pkg and general_mode_ctrl are compiled before it.
*/
`timescale 1ns/1ps
module test_transceiver_general_mode_config;
  import mode_cfg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, rxByte = 8'h00;
  logic regWrEn = 1'b0, regRdEn = 1'b0, rfCommActive = 1'b0;
  logic [15:0] modePreset = 16'h0000, crcRawResult = 16'h0000;
  logic rxFrameStart = 1'b0, rxByteValid = 1'b0, txRequest = 1'b0;
  logic readerMode = 1'b0, ownFieldOn = 1'b0, rxWaitRequest = 1'b0;
  logic targetMode = 1'b0, extFieldDetected = 1'b0;
  logic secureSignalIn = 1'b0, autoAnticollActive = 1'b0;
  logic [7:0] regRdData;
  logic [15:0] crcPresetValue, crcResultOut;
  logic crcMsbFirst, rxActive, txStart, txSyncPrefix, rxWaitCountStart;
  logic secureInputActive, envelopeN, modeDetectorRun, irq;
  int nFail = 0;
  int testsRun = 0;
  logic [31:0] seed = 32'hc36d;
  logic [31:0] w;
  logic [7:0] modeM = 8'h3b, statM = 8'h00, enM = 8'h00;
  logic msb;

  always #5 clk_sys = ~clk_sys;

  general_mode_ctrl u_dut (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .rfCommActive(rfCommActive),
    .modePreset(modePreset), .crcRawResult(crcRawResult),
    .crcMsbFirst(crcMsbFirst), .crcPresetValue(crcPresetValue),
    .crcResultOut(crcResultOut), .rxFrameStart(rxFrameStart),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxActive(rxActive),
    .txRequest(txRequest), .readerMode(readerMode),
    .ownFieldOn(ownFieldOn), .txStart(txStart),
    .txSyncPrefix(txSyncPrefix), .rxWaitRequest(rxWaitRequest),
    .targetMode(targetMode), .extFieldDetected(extFieldDetected),
    .rxWaitCountStart(rxWaitCountStart), .secureSignalIn(secureSignalIn),
    .secureInputActive(secureInputActive), .envelopeN(envelopeN),
    .autoAnticollActive(autoAnticollActive),
    .modeDetectorRun(modeDetectorRun), .irq(irq)
  );

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = b[7-i];
    return r;
  endfunction

  function automatic logic [15:0] presetM(input logic [1:0] s);
    case (s)
      2'b00: return 16'h0000;
      2'b01: return 16'h6363;
      2'b10: return 16'ha671;
      default: return 16'hffff;
    endcase
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      nFail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Model follows each write as the block should see it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    if (a == GEN_MODE_OFFSET && d[3] !== modeM[3])
      statM[0] = 1'b1;
    if (a == GEN_MODE_OFFSET)
      modeM = d;
    if (a == IRQ_CLEAR_OFFSET)
      statM = statM & ~d;
    if (a == IRQ_ENABLE_OFFSET)
      enM = d & 8'h03;
  endtask

  // Without the gap the read follows a write back to back
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp,
    input bit gap = 1'b1);
    if (gap)
      @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask

  task automatic irqChk();
    #1;
    chk(irq, |(statM & enM));
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    nFail++;
    finish_test();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rdChk(GEN_MODE_OFFSET, 8'h3b);
    @(posedge clk_sys);
    #1;
    chk(regRdData, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      w = xorshift();
      wr(GEN_MODE_OFFSET, w[7:0]);
      rdChk(GEN_MODE_OFFSET, w[7:0], i[0]);
    end
    rdChk(8'h33, 8'h00);
    wr(8'h33, 8'h5a);
    rdChk(GEN_MODE_OFFSET, modeM);
    rdChk(IRQ_STATUS_OFFSET, statM);
    // CRC order, reversal and preset, idle and in communication
    for (int i = 0; i < 8; i++)
    begin
      w = xorshift();
      msb = i[0] ^ i[1];
      wr(GEN_MODE_OFFSET, {msb, 5'h00, i[1:0]});
      @(posedge clk_sys);
      rfCommActive <= i[2];
      crcRawResult <= w[31:16];
      modePreset <= w[15:0];
      @(posedge clk_sys);
      #1;
      msb = msb && !i[2];
      chk(crcMsbFirst, msb);
      chk(crcResultOut, msb ? {rev8(w[31:24]), rev8(w[23:16])} : w[31:16]);
      chk(crcPresetValue, i[2] ? w[15:0] : presetM(i[1:0]));
    end
    // Receiver held off until the sync byte; stray byte never F0h
    wr(IRQ_CLEAR_OFFSET, 8'hff);
    wr(GEN_MODE_OFFSET, 8'h40);
    @(posedge clk_sys);
    rxFrameStart <= 1'b1;
    @(posedge clk_sys);
    rxFrameStart <= 1'b0;
    rxByteValid <= 1'b1;
    w = xorshift();
    rxByte <= w[7:0] | 8'h01;
    @(posedge clk_sys);
    rxByte <= SYNC_BYTE;
    #1;
    chk(rxActive, 16'h0000);
    @(posedge clk_sys);
    rxByteValid <= 1'b0;
    txRequest <= 1'b1;
    #1;
    chk(rxActive, 16'h0001);
    chk(txStart, 16'h0001);
    statM[1] = 1'b1;
    @(posedge clk_sys);
    txRequest <= 1'b0;
    #1;
    chk(txSyncPrefix, 16'h0001);
    rdChk(IRQ_STATUS_OFFSET, statM);
    // Field-gated transmit start and receive-wait start
    for (int k = 0; k < 16; k++)
    begin
      wr(GEN_MODE_OFFSET, {2'b00, k[3], k[3], 4'h0});
      @(posedge clk_sys);
      txRequest <= 1'b1;
      readerMode <= k[0];
      ownFieldOn <= k[1];
      rxWaitRequest <= 1'b1;
      targetMode <= k[0];
      extFieldDetected <= k[2];
      #1;
      chk(txStart, !(k[3] && k[0] && !k[1]));
      chk(rxWaitCountStart, !(k[3] && k[0] && !k[2]));
      @(posedge clk_sys);
      txRequest <= 1'b0;
      rxWaitRequest <= 1'b0;
      extFieldDetected <= 1'b1;
      #1;
      chk(txStart, 16'h0000);
      chk(txSyncPrefix, 16'h0000);
      chk(rxWaitCountStart, k[3] && k[0] && !k[2]);
      @(posedge clk_sys);
      #1;
      chk(rxWaitCountStart, 16'h0000);
    end
    // Secure input polarity, envelope and polarity-change event
    wr(IRQ_CLEAR_OFFSET, 8'hff);
    wr(IRQ_ENABLE_OFFSET, 8'h01);
    rdChk(IRQ_ENABLE_OFFSET, enM);
    rdChk(IRQ_CLEAR_OFFSET, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(GEN_MODE_OFFSET, {4'h0, k[1], 3'h0});
      @(posedge clk_sys);
      secureSignalIn <= k[0];
      @(posedge clk_sys);
      #1;
      chk(secureInputActive, k[1] ? k[0] : !k[0]);
      chk(envelopeN, k[1] ? !k[0] : k[0]);
      irqChk();
      rdChk(IRQ_STATUS_OFFSET, statM);
      wr(IRQ_CLEAR_OFFSET, 8'h01);
      irqChk();
    end
    wr(GEN_MODE_OFFSET, 8'h00);
    wr(IRQ_ENABLE_OFFSET, 8'h00);
    irqChk();
    wr(IRQ_ENABLE_OFFSET, 8'h01);
    irqChk();
    wr(IRQ_CLEAR_OFFSET, 8'h01);
    irqChk();
    // Mode detector gated by the disable bit and the command
    for (int k = 0; k < 4; k++)
    begin
      wr(GEN_MODE_OFFSET, {5'h00, k[1], 2'h0});
      @(posedge clk_sys);
      autoAnticollActive <= k[0];
      @(posedge clk_sys);
      #1;
      chk(modeDetectorRun, k[0] && !k[1]);
    end
    // Second reset in mid-run
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    statM = 8'h00;
    enM = 8'h00;
    modeM = GEN_MODE_RESET;
    rdChk(GEN_MODE_OFFSET, 8'h3b);
    rdChk(IRQ_STATUS_OFFSET, 8'h00);
    irqChk();
    chk(rxActive, 16'h0000);
    // Sync detection off after reset: a frame unlocks at once
    @(posedge clk_sys);
    rxFrameStart <= 1'b1;
    @(posedge clk_sys);
    rxFrameStart <= 1'b0;
    #1;
    chk(rxActive, 16'h0001);
    finish_test();
  end
endmodule // test_transceiver_general_mode_config
